// file: bus_master_model.sv
`timescale 1ns/1ns
// ****
// Bus master
// ****
module bus_master_model
(
  input wire logic mclk,
  input wire logic sda_line,
  output logic scl,
  output logic sda
);
  initial
  begin
    scl = 1'b1;
    sda = 1'b1;
  end
  task automatic hp;
    repeat (8) @(posedge mclk);
  endtask : hp
  task automatic start;
    hp;
    sda <= 1'b1;
    hp;
    scl <= 1'b1;
    hp;
    sda <= 1'b0;
    hp;
    scl <= 1'b0;
  endtask : start
  task automatic stop;
    hp;
    sda <= 1'b0;
    hp;
    scl <= 1'b1;
    hp;
    sda <= 1'b1;
    hp;
  endtask : stop
  // Data moves mid-low so no edge looks like start or stop
  task automatic bit_x(input logic b, output logic r);
    hp;
    sda <= b;
    hp;
    scl <= 1'b1;
    hp;
    r = sda_line;
    scl <= 1'b0;
  endtask : bit_x
  task automatic xfer(input logic [7:0] d, input logic nak, output logic [7:0] q,
                      output logic ack);
    for (int i = 7; i >= 0; i--)
      bit_x(d[i], q[i]);
    bit_x(nak, ack);
  endtask : xfer
endmodule : bus_master_model

// file: bus_sync.sv
`timescale 1ns/1ns
module bus_sync
(
  input wire logic mclk,
  input wire logic rst,
  input wire logic din,
  output logic dout
);
  logic stage1;
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      stage1 <= 1'b1;
      dout <= 1'b1;
    end
    else
    begin
      stage1 <= din;
      dout <= stage1;
    end
  end
endmodule : bus_sync

// file: twm_params.svh
`ifndef TWM_PARAMS_SVH
`define TWM_PARAMS_SVH
`define MEM_TARGET_ID 4'ha
`define REG_TARGET_ID 4'hd
`define REG_TOP_ADDR 8'h18
`define MEM_ADDR_BITS_DEFAULT 15
`define BYTE_BITS 8
`endif

// file: twm_pkg.sv
package twm_pkg;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_SLAVE = 3'b001,
    ST_ADDR_HI = 3'b010,
    ST_ADDR_LO = 3'b011,
    ST_WDATA = 3'b100,
    ST_RDATA = 3'b101
  } twm_state_t;
endpackage : twm_pkg

// file: two_wire_mem_companion_slave.sv
`timescale 1ns/1ns
`include "twm_params.svh"
// Operation
// - Read: send byte, ack continues, nack ends
// - Write: take byte, then drive ack
// - All bytes shifted most significant first
// - Endless write bursts, pointer wraps to zero
// - Commit after eighth bit; earlier abort keeps
// - Read starts from memory latch next clock
// - Pointer advances each byte; ack continues
// - Read past top wraps to zero
// - Repeated start after address gives random read
// - Register write uses one address byte
// - Register read from register pointer, increments
// - Memory and register pointers independent
// - Memory address width follows array density
// - Answer memory and register target ids
// - Select bits match pins; bit0 read
// - Register address beyond top gets nack
// - Memory address sent high byte first
module two_wire_mem_companion_slave
  import twm_pkg::*;
#(
  parameter int MEM_ADDR_BITS = `MEM_ADDR_BITS_DEFAULT
)
(
  input wire logic mclk,
  input wire logic rst,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  input wire logic [1:0] dev_sel,
  output logic mem_we,
  output logic [MEM_ADDR_BITS-1:0] mem_addr,
  output logic [7:0] mem_wdata,
  input wire logic [7:0] mem_rdata,
  output logic reg_we,
  output logic [4:0] reg_addr,
  output logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata
);
  initial
  begin
    if (!(MEM_ADDR_BITS == 15 || MEM_ADDR_BITS == 13 || MEM_ADDR_BITS == 11 ||
          MEM_ADDR_BITS == 9))
      $error("MEM_ADDR_BITS must be 15, 13, 11 or 9");
  end

  // ****************************************
  // Pin synchronisation and bus conditions
  // ****************************************
  logic scl_s;
  logic sda_s;
  logic scl_d;
  logic sda_d;
  bus_sync u_scl (.mclk(mclk), .rst(rst), .din(scl_in), .dout(scl_s));
  bus_sync u_sda (.mclk(mclk), .rst(rst), .din(sda_in), .dout(sda_s));
  logic [1:0] sel_s;
  bus_sync u_sel0 (.mclk(mclk), .rst(rst), .din(dev_sel[0]), .dout(sel_s[0]));
  bus_sync u_sel1 (.mclk(mclk), .rst(rst), .din(dev_sel[1]), .dout(sel_s[1]));

  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      scl_d <= 1'b1;
      sda_d <= 1'b1;
    end
    else
    begin
      scl_d <= scl_s;
      sda_d <= sda_s;
    end
  end

  logic scl_rise;
  logic scl_fall;
  logic start_cond;
  logic stop_cond;
  assign scl_rise = scl_s & ~scl_d;
  assign scl_fall = ~scl_s & scl_d;
  assign start_cond = scl_s & scl_d & sda_d & ~sda_s;
  assign stop_cond = scl_s & scl_d & ~sda_d & sda_s;

  // ****************************************
  // Byte engine
  // ****************************************
  twm_state_t state;
  logic [3:0] bit_cnt;
  logic [7:0] shreg;
  logic [7:0] txreg;
  logic reg_target;
  logic ack_phase;
  logic ack_wait;
  logic ack_drive;
  logic tx_active;
  logic [MEM_ADDR_BITS-1:0] mem_ptr;
  logic [4:0] reg_ptr;
  logic [7:0] addr_hi;
  logic [7:0] rx_byte;
  logic byte_done;
  logic master_ack;

  // Byte completes on the eighth rising edge; ack slot is the ninth clock
  assign rx_byte = {shreg[6:0], sda_s};
  assign byte_done = scl_rise && !ack_phase && !ack_wait && bit_cnt == 4'h7;
  assign master_ack = ~sda_s;
  assign mem_addr = mem_ptr;
  assign reg_addr = reg_ptr;

  logic addr_match;
  logic id_mem;
  logic id_reg;
  assign id_mem = rx_byte[7:4] == `MEM_TARGET_ID;
  assign id_reg = rx_byte[7:4] == `REG_TARGET_ID;
  assign addr_match = (id_mem | id_reg) && rx_byte[2:1] == sel_s;

  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      state <= ST_IDLE;
      bit_cnt <= 4'h0;
      shreg <= 8'h00;
      ack_phase <= 1'b0;
      ack_wait <= 1'b0;
      ack_drive <= 1'b0;
      reg_target <= 1'b0;
      addr_hi <= 8'h00;
      mem_we <= 1'b0;
      reg_we <= 1'b0;
      mem_wdata <= 8'h00;
      reg_wdata <= 8'h00;
      mem_ptr <= '0;
      reg_ptr <= 5'h00;
    end
    else
    begin
      mem_we <= 1'b0;
      reg_we <= 1'b0;
      // Start or stop aborts; a partial byte is never committed
      if (start_cond)
      begin
        state <= ST_SLAVE;
        bit_cnt <= 4'h0;
        ack_phase <= 1'b0;
        ack_wait <= 1'b0;
        ack_drive <= 1'b0;
      end
      else if (stop_cond)
      begin
        state <= ST_IDLE;
        ack_phase <= 1'b0;
        ack_wait <= 1'b0;
        ack_drive <= 1'b0;
      end
      else if (state != ST_IDLE)
      begin
        if (scl_rise && !ack_phase)
        begin
          shreg <= rx_byte;
          bit_cnt <= bit_cnt + 4'h1;
        end
        if (byte_done)
        begin
          ack_wait <= 1'b1;
          bit_cnt <= 4'h0;
          unique case (state)
            ST_SLAVE:
            begin
              ack_drive <= addr_match;
              reg_target <= id_reg;
              if (!addr_match)
                state <= ST_IDLE;
              else if (rx_byte[0])
                state <= ST_RDATA;
              else
                state <= id_reg ? ST_ADDR_LO : ST_ADDR_HI;
            end
            ST_ADDR_HI:
            begin
              addr_hi <= rx_byte;
              ack_drive <= 1'b1;
              state <= ST_ADDR_LO;
            end
            ST_ADDR_LO:
            begin
              if (reg_target)
              begin
                // Out-of-range register address refused
                ack_drive <= rx_byte <= `REG_TOP_ADDR;
                if (rx_byte <= `REG_TOP_ADDR)
                  reg_ptr <= rx_byte[4:0];
                state <= (rx_byte <= `REG_TOP_ADDR) ? ST_WDATA : ST_IDLE;
              end
              else
              begin
                ack_drive <= 1'b1;
                mem_ptr <= MEM_ADDR_BITS'({addr_hi, rx_byte});
                state <= ST_WDATA;
              end
            end
            ST_WDATA:
            begin
              ack_drive <= 1'b1;
              if (reg_target)
              begin
                reg_wdata <= rx_byte;
                reg_we <= 1'b1;
              end
              else
              begin
                mem_wdata <= rx_byte;
                mem_we <= 1'b1;
              end
            end
            ST_RDATA:
            begin
              ack_drive <= 1'b0;
              // Pointer advances just before the ack slot
              if (reg_target)
                reg_ptr <= (reg_ptr == `REG_TOP_ADDR) ? 5'h00 : reg_ptr + 5'h01;
              else
                mem_ptr <= mem_ptr + 1'b1;
            end
            default:
              state <= ST_IDLE;
          endcase
        end
        // Ack slot opens at the fall after bit eight, never while SCL is high
        else if (scl_fall && ack_wait)
        begin
          ack_wait <= 1'b0;
          ack_phase <= 1'b1;
        end
        else if (scl_rise && ack_phase && state == ST_RDATA && !master_ack)
          state <= ST_IDLE;
        else if (scl_fall && ack_phase)
        begin
          ack_phase <= 1'b0;
          ack_drive <= 1'b0;
        end
        // Write pointer steps after the commit so the strobe sees the old address
        if (mem_we)
          mem_ptr <= mem_ptr + 1'b1;
        if (reg_we)
          reg_ptr <= (reg_ptr == `REG_TOP_ADDR) ? 5'h00 : reg_ptr + 5'h01;
      end
    end
  end

  // ****************************************
  // Transmit path
  // ****************************************
  // Data loads at the fall ending the ack slot, so read data leads each byte
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      txreg <= 8'hff;
      tx_active <= 1'b0;
    end
    else if (start_cond || stop_cond || state != ST_RDATA)
    begin
      tx_active <= 1'b0;
      txreg <= 8'hff;
    end
    else if (scl_fall && ack_phase)
    begin
      txreg <= reg_target ? reg_rdata : mem_rdata;
      tx_active <= 1'b1;
    end
    else if (scl_fall && tx_active && !ack_phase)
      txreg <= {txreg[6:0], 1'b1};
    else if (ack_phase)
      tx_active <= 1'b0;
  end

  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      sda_out <= 1'b1;
      sda_oe <= 1'b0;
    end
    else
    begin
      sda_out <= 1'b0;
      sda_oe <= (ack_phase && ack_drive) || (tx_active && !ack_phase && !txreg[7]);
    end
  end
endmodule : two_wire_mem_companion_slave

// file: two_wire_mem_companion_slave_bench.sv
`timescale 1ns/1ns
`include "twm_params.svh"
module two_wire_mem_companion_slave_bench
  import twm_pkg::*;
;
  // ****
  // Bench
  // ****
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic [1:0] dev_sel = 2'b10;
  logic [7:0] mem [0:511];
  logic [7:0] regs [0:24];
  logic sda_out, sda_oe, mem_we, reg_we, scl, sda_m, a;
  logic [8:0] mem_addr;
  logic [4:0] reg_addr;
  logic [7:0] mem_wdata, reg_wdata, q;
  int failures = 0;
  int check_count = 0;
  int cyc = 0;
  wire logic sda_line = sda_m & ~sda_oe;
  `define CHK(x, y) begin check_count++; if ((x) !== (y)) begin failures++; \
    $display("mismatch %0t %h %h", $time, x, y); end end
  always #50 mclk = ~mclk;
  bus_master_model m (.mclk(mclk), .sda_line(sda_line), .scl(scl), .sda(sda_m));
  // Small array keeps the top-address wrap quick to reach
  two_wire_mem_companion_slave #(.MEM_ADDR_BITS(9)) dut (.mclk(mclk), .rst(rst),
    .scl_in(scl), .sda_in(sda_line), .sda_out(sda_out), .sda_oe(sda_oe), .dev_sel(dev_sel),
    .mem_we(mem_we), .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_rdata(mem[mem_addr]),
    .reg_we(reg_we), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(regs[reg_addr]));
  always @(posedge mclk)
  begin
    if (mem_we) mem[mem_addr] <= mem_wdata;
    if (reg_we) regs[reg_addr] <= reg_wdata;
    cyc++;
    if (cyc == 30000)
    begin
      failures++;
      close_out;
    end
  end
  function automatic logic [7:0] sa(input logic [3:0] id, input logic rd);
    return {id, 1'b0, 2'b10, rd};
  endfunction : sa
  task automatic close_out;
    if (failures == 0 && check_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : close_out
  task automatic t_write;
    m.start;
    m.xfer(sa(`MEM_TARGET_ID, 1'b0), 1'b1, q, a);
    `CHK(a, 1'b0)
    m.xfer(8'hff, 1'b1, q, a);
    m.xfer(8'hff, 1'b1, q, a);
    `CHK(a, 1'b0)
    m.xfer(8'hc3, 1'b1, q, a);
    `CHK(a, 1'b0)
    m.xfer(8'h3c, 1'b1, q, a);
    m.stop;
    `CHK(mem[9'h1ff], 8'hc3)
    `CHK(mem[0], 8'h3c)
    m.start;
    m.xfer(sa(`MEM_TARGET_ID, 1'b0), 1'b1, q, a);
    m.xfer(8'h00, 1'b1, q, a);
    m.xfer(8'h05, 1'b1, q, a);
    for (int i = 0; i < 4; i++)
      m.bit_x(1'b0, a);
    m.stop;
    `CHK(mem[5], 8'h05)
  endtask : t_write
  task automatic t_read;
    m.start;
    m.xfer(sa(`MEM_TARGET_ID, 1'b0), 1'b1, q, a);
    m.xfer(8'h01, 1'b1, q, a);
    m.xfer(8'hff, 1'b1, q, a);
    m.start;
    m.xfer(sa(`MEM_TARGET_ID, 1'b1), 1'b1, q, a);
    `CHK(a, 1'b0)
    m.xfer(8'hff, 1'b0, q, a);
    `CHK(q, 8'hc3)
    m.xfer(8'hff, 1'b1, q, a);
    `CHK(q, 8'h3c)
    m.stop;
  endtask : t_read
  task automatic t_regs;
    m.start;
    m.xfer(sa(`REG_TARGET_ID, 1'b0), 1'b1, q, a);
    m.xfer(8'h18, 1'b1, q, a);
    `CHK(a, 1'b0)
    m.xfer(8'h77, 1'b1, q, a);
    m.stop;
    `CHK(regs[24], 8'h77)
    m.start;
    m.xfer(sa(`REG_TARGET_ID, 1'b1), 1'b1, q, a);
    m.xfer(8'hff, 1'b1, q, a);
    `CHK(q, 8'h80)
    m.start;
    m.xfer(sa(`MEM_TARGET_ID, 1'b1), 1'b1, q, a);
    m.xfer(8'hff, 1'b1, q, a);
    `CHK(q, 8'h01)
    m.stop;
  endtask : t_regs
  task automatic t_refuse;
    dev_sel <= 2'b01;
    m.start;
    m.xfer(sa(`MEM_TARGET_ID, 1'b0), 1'b1, q, a);
    `CHK(a, 1'b1)
    m.stop;
    dev_sel <= 2'b10;
    m.start;
    m.xfer(sa(`REG_TARGET_ID, 1'b0), 1'b1, q, a);
    m.xfer(8'h19, 1'b1, q, a);
    `CHK(a, 1'b1)
    m.stop;
  endtask : t_refuse
  initial
  begin
    for (int i = 0; i < 512; i++)
      mem[i] = i[7:0];
    for (int i = 0; i < 25; i++)
      regs[i] = 8'h80 | i[7:0];
    repeat (20) @(posedge mclk);
    rst <= 1'b0;
    repeat (4) @(posedge mclk);
    t_write;
    t_read;
    t_regs;
    t_refuse;
    close_out;
  end
endmodule : two_wire_mem_companion_slave_bench

// file: two_wire_mem_companion_slave_sva.sv
`timescale 1ns/1ns
`include "twm_params.svh"
// ****
// Checker
// ****
module two_wire_mem_companion_slave_sva
  import twm_pkg::*;
#(
  parameter int MEM_ADDR_BITS = 15
)
(
  input wire logic mclk,
  input wire logic rst,
  input wire logic scl_in,
  input wire logic sda_in,
  input wire logic sda_out,
  input wire logic sda_oe,
  input wire logic [1:0] dev_sel,
  input wire logic mem_we,
  input wire logic [MEM_ADDR_BITS-1:0] mem_addr,
  input wire logic [7:0] mem_wdata,
  input wire logic [7:0] mem_rdata,
  input wire logic reg_we,
  input wire logic [4:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata
);
  logic [MEM_ADDR_BITS-1:0] next_mem;
  logic [4:0] next_reg;
  always_ff @(posedge mclk)
    if (mem_we) next_mem <= mem_addr + 1'b1;
  always_ff @(posedge mclk)
    if (reg_we) next_reg <= (reg_addr == `REG_TOP_ADDR) ? 5'h00 : reg_addr + 5'h01;
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  we_pulse_a: assert property (mem_we |=> !mem_we) else $error("long strobe");
  commit_high_a: assert property (mem_we |-> scl_in) else $error("early commit");
  mem_step_a: assert property (mem_we |=> ##[0:1] mem_addr == next_mem)
    else $error("memory pointer step");
  reg_step_a: assert property (reg_we |=> ##[0:1] reg_addr == next_reg)
    else $error("register pointer step");
  reg_keep_a: assert property (mem_we |=> $stable(reg_addr)) else $error("reg moved");
  mem_keep_a: assert property (reg_we |=> $stable(mem_addr)) else $error("mem moved");
  reg_top_a: assert property (reg_we |-> reg_addr <= 5'h18) else $error("reg too high");
  oe_low_a: assert property ($changed(sda_oe) |-> !scl_in) else $error("drive in high");
  cover property (mem_we);
  cover property (reg_we);
  cover property ($rose(sda_oe));
endmodule : two_wire_mem_companion_slave_sva
bind two_wire_mem_companion_slave two_wire_mem_companion_slave_sva
  #(.MEM_ADDR_BITS(MEM_ADDR_BITS)) chk (.mclk(mclk), .rst(rst), .scl_in(scl_in),
  .sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe), .dev_sel(dev_sel), .mem_we(mem_we),
  .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_rdata(mem_rdata), .reg_we(reg_we),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata));
